// >>> logic/epp_consts.svh
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH
// Summary of operation
// - four warning entries at sub 1..4; sub 0 reads constant 4
// - entry bits 29..0 hold the threshold, zero after reset
// - entry bit 30 enables the undershoot check, default off
// - entry bit 31 enables the exceed check, default off
// - read-only flag byte, two bits per warning position, bits 0..7
// - signed 32-bit offset added to the scaled position, default zero
// - speed is raw sample difference over 5 ms, signed 16 bits
// - acceleration is speed difference over 5 ms, signed 16 bits
// - layout select: bits 7..4 second, 3..0 first message, reset 00h
// - position bytes 0..3 LSB first; flags byte 4; speed/accel 4..7
// - flags layout in event mode sends the message on any flag change
// - layout select is volatile; master rewrites it after every reset
// - identifier bit 31 disables a message; first on, second off
// - operating bit 0 selects counting direction, default 0
// - operating bit 1 enables hardware self-check, default 0
// - operating bit 2 enables scaling, default 0
// - operating bit 12 residual compensation acts after encoder reset
// - operating bits 3..11 and 13..15 read as zero
// - direction change or scaling switched on clears the preset
// - writing steps per revolution clears the preset
// - scaling multiplies position by steps over physical resolution
// - steps per revolution 0..physical resolution, default physical
`define EPP_IDX_WARN    16'h2000
`define EPP_IDX_OFFS    16'h2001
`define EPP_IDX_SPEED   16'h2002
`define EPP_IDX_ACCEL   16'h2003
`define EPP_IDX_FLAGS   16'h2004
`define EPP_IDX_LAYOUT  16'h2005
`define EPP_IDX_OPER    16'h6000
`define EPP_IDX_STEPS   16'h6001
`define EPP_IDX_ID1     16'h1800
`define EPP_IDX_ID2     16'h1802
`define EPP_WARN_COUNT  32'h0000_0004
`define EPP_THR_MSB     29
`define EPP_UNDER_BIT   30
`define EPP_EXCEED_BIT  31
`define EPP_ID_DIS_BIT  31
`define EPP_OP_DIR      0
`define EPP_OP_CHECK    1
`define EPP_OP_SCALE    2
`define EPP_OP_RESID    12
`define EPP_OP_MASK     16'h1007
`define EPP_ID1_RST     32'h0000_0000
`define EPP_ID2_RST     32'h8000_0000
`define EPP_LAY_DEF     4'h0
`define EPP_LAY_FLAGS   4'h1
`define EPP_LAY_SPEED   4'h2
`define EPP_LEN_POS     4'h4
`define EPP_LEN_FLAGS   4'h5
`define EPP_LEN_SPEED   4'h8
`define EPP_T5MS_NS     5000000
`define EPP_CLK_NS      10
`define EPP_PHYS_RES    32'h0000_2000
`define EPP_FIFO_DEPTH  32
`endif

// >>> logic/epp_pkg.sv
package epp_pkg;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  sub;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } epp_objreq_s;
  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } epp_objrsp_s;
  typedef struct packed {
    logic        sel;
    logic [3:0]  len;
    logic [63:0] data;
  } epp_msg_s;
endpackage

// >>> logic/epp_position.sv
`timescale 1ns/100ps
`include "epp_consts.svh"

module epp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } epp_fifo_s;
  epp_fifo_s r_reg;
  epp_fifo_s r_next;
  logic      push;
  logic      pop;

  assign in_ready  = (r_reg.cnt != CW'(D));
  assign out_valid = (r_reg.cnt != '0);
  assign out_data  = r_reg.mem[r_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = (r_reg.wp == AW'(D - 1)) ? '0 : AW'(r_reg.wp + 1'b1);
    end
    if (pop) begin
      r_next.rp = (r_reg.rp == AW'(D - 1)) ? '0 : AW'(r_reg.rp + 1'b1);
    end
    if (push && !pop) begin
      r_next.cnt = CW'(r_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      r_next.cnt = CW'(r_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

module epp_position
  import epp_pkg::*;
#(
  parameter int unsigned TICKS = `EPP_T5MS_NS / `EPP_CLK_NS
) (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire epp_pkg::epp_objreq_s OBJ_REQ,
  output epp_pkg::epp_objrsp_s     OBJ_RSP,
  input  wire logic [31:0]         RAW_POS,
  input  wire logic                RAW_VALID,
  input  wire logic [1:0]          TX_REQ,
  input  wire logic [1:0]          EVENT_MODE,
  input  wire logic                ENC_RESET,
  output epp_pkg::epp_msg_s        MSG_OUT,
  output logic                     MSG_VALID,
  input  wire logic                MSG_READY,
  output logic                     PRESET_CLEAR,
  output logic                     SELF_CHECK_EN,
  output logic                     RESID_COMP,
  output logic [31:0]              POSITION
);
  import epp_pkg::*;

  typedef struct packed {
    logic [3:0][31:0] warn;
    logic [31:0]      offs;
    logic [15:0]      speed;
    logic [15:0]      accel;
    logic [7:0]       flags;
    logic [7:0]       layout;
    logic [15:0]      op;
    logic [31:0]      steps;
    logic [1:0][31:0] cobid;
    logic [31:0]      raw;
    logic [31:0]      prev_raw;
    logic [31:0]      pos;
    logic             pvld;
    logic [19:0]      tcnt;
    logic [1:0]       pend;
    logic             resid;
    logic             pclr;
    epp_objrsp_s      rsp;
  } epp_state_s;

  epp_state_s r_reg;
  epp_state_s r_next;
  epp_msg_s   fin_data;
  logic       fin_valid;
  logic       fin_ready;
  logic       tick;
  logic       flag_chg;

  // ----------------------------------------------------------------
  // message assembly
  // ----------------------------------------------------------------
  function automatic epp_msg_s build(input logic sel, input logic [3:0] lay,
                                     input epp_state_s s);
    epp_msg_s m;
    m      = '0;
    m.sel  = sel;
    m.len  = `EPP_LEN_POS;
    m.data = {32'h0000_0000, s.pos};
    case (lay)
      `EPP_LAY_FLAGS: begin
        m.len         = `EPP_LEN_FLAGS;
        m.data[39:32] = s.flags;
      end
      `EPP_LAY_SPEED: begin
        m.len         = `EPP_LEN_SPEED;
        m.data[47:32] = s.speed;
        m.data[63:48] = s.accel;
      end
      default: begin
        m.len = `EPP_LEN_POS;
      end
    endcase
    return m;
  endfunction

  assign tick = (r_reg.tcnt == 20'(TICKS - 1));

  always_comb begin
    logic [31:0] rd;
    logic        bad;
    logic        ro;
    logic        wok;
    logic [1:0]  wi;
    logic [15:0] nop;
    logic [31:0] pd;
    logic [31:0] ps;
    logic [63:0] prod;
    logic [7:0]  f;
    logic [15:0] spd;
    logic [1:0]  newreq;
    logic [1:0]  pushed;
    logic [3:0]  lay;
    rd     = '0;
    bad    = 1'b0;
    ro     = 1'b0;
    wok    = 1'b0;
    wi     = 2'(OBJ_REQ.sub - 8'h01);
    nop    = OBJ_REQ.wdata[15:0] & `EPP_OP_MASK;
    pd     = '0;
    ps     = '0;
    prod   = '0;
    f      = '0;
    spd    = '0;
    newreq = '0;
    pushed = '0;
    lay    = '0;
    flag_chg  = 1'b0;
    fin_valid = 1'b0;
    fin_data  = '0;
    r_next = r_reg;
    r_next.rsp.ack = 1'b0;
    r_next.rsp.err = 1'b0;
    r_next.pclr    = 1'b0;

    // --------------------------------------------------------------
    // object access
    // --------------------------------------------------------------
    case (OBJ_REQ.idx)
      `EPP_IDX_WARN: begin
        if (OBJ_REQ.sub == 8'h00) begin
          rd = `EPP_WARN_COUNT;
          ro = 1'b1;
        end else if (OBJ_REQ.sub <= 8'h04) begin
          rd = r_reg.warn[wi];
        end else begin
          bad = 1'b1;
        end
      end
      `EPP_IDX_OFFS:   rd = r_reg.offs;
      `EPP_IDX_SPEED:  rd = {16'h0000, r_reg.speed};
      `EPP_IDX_ACCEL:  rd = {16'h0000, r_reg.accel};
      `EPP_IDX_FLAGS: begin
        rd = {24'h00_0000, r_reg.flags};
        ro = 1'b1;
      end
      `EPP_IDX_LAYOUT: rd = {24'h00_0000, r_reg.layout};
      `EPP_IDX_OPER:   rd = {16'h0000, r_reg.op};
      `EPP_IDX_STEPS: begin
        rd = r_reg.steps;
        if (OBJ_REQ.wr && OBJ_REQ.wdata > `EPP_PHYS_RES) begin
          bad = 1'b1;
        end
      end
      `EPP_IDX_ID1, `EPP_IDX_ID2: begin
        rd  = r_reg.cobid[OBJ_REQ.idx == `EPP_IDX_ID2];
        bad = (OBJ_REQ.sub != 8'h01);
      end
      default: bad = 1'b1;
    endcase
    if (OBJ_REQ.idx != `EPP_IDX_WARN && OBJ_REQ.idx != `EPP_IDX_ID1 &&
        OBJ_REQ.idx != `EPP_IDX_ID2 && OBJ_REQ.sub != 8'h00) begin
      bad = 1'b1;
    end
    if (OBJ_REQ.wr || OBJ_REQ.rd) begin
      r_next.rsp.ack   = 1'b1;
      r_next.rsp.err   = bad || (OBJ_REQ.wr && ro);
      r_next.rsp.rdata = (bad || OBJ_REQ.wr) ? '0 : rd;
    end
    wok = OBJ_REQ.wr && !bad && !ro;
    if (wok) begin
      case (OBJ_REQ.idx)
        `EPP_IDX_WARN:   r_next.warn[wi] = OBJ_REQ.wdata;
        `EPP_IDX_OFFS:   r_next.offs = OBJ_REQ.wdata;
        `EPP_IDX_LAYOUT: r_next.layout = OBJ_REQ.wdata[7:0];
        `EPP_IDX_OPER: begin
          r_next.op = nop;
          if (nop[`EPP_OP_DIR] != r_reg.op[`EPP_OP_DIR] ||
              (nop[`EPP_OP_SCALE] && !r_reg.op[`EPP_OP_SCALE])) begin
            r_next.pclr = 1'b1;
          end
        end
        `EPP_IDX_STEPS: begin
          r_next.steps = OBJ_REQ.wdata;
          r_next.pclr  = 1'b1;
        end
        `EPP_IDX_ID1:    r_next.cobid[0] = OBJ_REQ.wdata;
        `EPP_IDX_ID2:    r_next.cobid[1] = OBJ_REQ.wdata;
        default:         r_next.pend = r_reg.pend;
      endcase
    end

    // --------------------------------------------------------------
    // position pipeline
    // --------------------------------------------------------------
    // combinational divide keeps latency at one cycle; costs area
    r_next.pvld = RAW_VALID;
    if (RAW_VALID) begin
      r_next.raw = RAW_POS;
      pd = r_reg.op[`EPP_OP_DIR] ? 32'(32'h0 - RAW_POS) : RAW_POS;
      prod = 64'(pd) * 64'(r_reg.steps);
      ps = r_reg.op[`EPP_OP_SCALE] ?
           32'(prod / 64'(`EPP_PHYS_RES)) : pd;
      r_next.pos = 32'(ps + r_reg.offs);
    end
    if (r_reg.pvld) begin
      for (int i = 0; i < 4; i++) begin
        f[2*i]   = r_reg.warn[i][`EPP_EXCEED_BIT] &&
                   r_reg.pos > {2'b00, r_reg.warn[i][`EPP_THR_MSB:0]};
        f[2*i+1] = r_reg.warn[i][`EPP_UNDER_BIT] &&
                   r_reg.pos < {2'b00, r_reg.warn[i][`EPP_THR_MSB:0]};
      end
      r_next.flags = f;
      flag_chg     = (f != r_reg.flags);
    end

    // --------------------------------------------------------------
    // speed and acceleration
    // --------------------------------------------------------------
    // raw samples are unscaled, so the figures ignore direction bit
    r_next.tcnt = tick ? '0 : 20'(r_reg.tcnt + 1'b1);
    if (tick) begin
      spd             = 16'(r_reg.raw - r_reg.prev_raw);
      r_next.prev_raw = r_reg.raw;
      r_next.speed    = spd;
      r_next.accel    = 16'(spd - r_reg.speed);
    end

    // --------------------------------------------------------------
    // message requests
    // --------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      lay = i[0] ? r_reg.layout[7:4] : r_reg.layout[3:0];
      newreq[i] = (TX_REQ[i] || (flag_chg && EVENT_MODE[i] &&
                   lay == `EPP_LAY_FLAGS)) &&
                  !r_reg.cobid[i][`EPP_ID_DIS_BIT];
    end
    if (r_reg.pend[0]) begin
      fin_valid = 1'b1;
      fin_data  = build(1'b0, r_reg.layout[3:0], r_reg);
      pushed[0] = fin_ready;
    end else if (r_reg.pend[1]) begin
      fin_valid = 1'b1;
      fin_data  = build(1'b1, r_reg.layout[7:4], r_reg);
      pushed[1] = fin_ready;
    end
    // a request in the push cycle stays pending
    r_next.pend = (r_reg.pend & ~pushed) | newreq;

    if (ENC_RESET) begin
      r_next.resid = r_reg.op[`EPP_OP_RESID];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r_reg          <= '0;
      r_reg.steps    <= `EPP_PHYS_RES;
      r_reg.cobid[0] <= `EPP_ID1_RST;
      r_reg.cobid[1] <= `EPP_ID2_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  epp_fifo #(
    .W ($bits(epp_msg_s)),
    .D (`EPP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (fin_data),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .out_data  (MSG_OUT),
    .out_valid (MSG_VALID),
    .out_ready (MSG_READY)
  );

  assign OBJ_RSP       = r_reg.rsp;
  assign PRESET_CLEAR  = r_reg.pclr;
  assign SELF_CHECK_EN = r_reg.op[`EPP_OP_CHECK];
  assign RESID_COMP    = r_reg.resid;
  assign POSITION      = r_reg.pos;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_count_read: assert property (
    OBJ_REQ.rd && OBJ_REQ.idx == `EPP_IDX_WARN && OBJ_REQ.sub == 8'h00
    |=> OBJ_RSP.ack && !OBJ_RSP.err && OBJ_RSP.rdata == `EPP_WARN_COUNT)
    else $error("count sub-entry read wrong");
  a_exceed_flag: assert property (
    r_reg.pvld && r_reg.warn[0][`EPP_EXCEED_BIT] &&
    r_reg.pos > {2'b00, r_reg.warn[0][`EPP_THR_MSB:0]} |=> r_reg.flags[0])
    else $error("exceed flag missing");
  a_under_flag: assert property (
    r_reg.pvld && !r_reg.warn[1][`EPP_UNDER_BIT] |=> !r_reg.flags[3])
    else $error("disabled undershoot flag set");
  a_offset_add: assert property (
    RAW_VALID && !r_reg.op[`EPP_OP_DIR] && !r_reg.op[`EPP_OP_SCALE]
    |=> POSITION == 32'($past(RAW_POS) + $past(r_reg.offs)))
    else $error("offset not applied");
  a_speed_diff: assert property (
    tick |=> r_reg.speed == 16'($past(r_reg.raw) - $past(r_reg.prev_raw)))
    else $error("speed difference wrong");
  a_oper_zero: assert property (
    (r_reg.op & ~`EPP_OP_MASK) == 16'h0000)
    else $error("unused operating bits set");
  a_preset_steps: assert property (
    OBJ_REQ.wr && OBJ_REQ.idx == `EPP_IDX_STEPS && OBJ_REQ.sub == 8'h00 &&
    OBJ_REQ.wdata <= `EPP_PHYS_RES |=> PRESET_CLEAR)
    else $error("preset not cleared");
  a_msg_enable: assert property (
    TX_REQ[1] && r_reg.cobid[1][`EPP_ID_DIS_BIT] |=> !r_reg.pend[1] ||
    $past(r_reg.pend[1]))
    else $error("disabled message queued");
  a_resid_hold: assert property (
    !ENC_RESET |=> $stable(RESID_COMP))
    else $error("compensation changed without reset");
  a_flag_event: assert property (
    flag_chg && EVENT_MODE[0] && r_reg.layout[3:0] == `EPP_LAY_FLAGS &&
    !r_reg.cobid[0][`EPP_ID_DIS_BIT] |=> r_reg.pend[0])
    else $error("flag change not queued");

  c_speed_msg: cover property (fin_valid && fin_ready &&
                               fin_data.len == `EPP_LEN_SPEED);
  c_flag_event: cover property (flag_chg && EVENT_MODE[0]);
  c_fifo_full:  cover property (fin_valid && !fin_ready);
endmodule

// >>> test/epp_master_model.sv
`timescale 1ns/100ps
// ----
// fieldbus master taking process messages
// ----
module epp_master_model
  import epp_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire epp_pkg::epp_msg_s MSG_OUT,
  input  wire logic              MSG_VALID,
  input  wire logic              STALL,
  output logic                   MSG_READY
);
  epp_msg_s    q[$];
  logic [31:0] rs = 32'h1234;
  // random ready: a busy master does not take every cycle
  always @(posedge CLK) begin
    if (RST_N && MSG_VALID && MSG_READY) q.push_back(MSG_OUT);
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    #1 MSG_READY = !STALL && rs[0];
  end
endmodule

// >>> test/encoder_position_processing_tb.sv
`timescale 1ns/100ps
// ----
// bench
// ----
module encoder_position_processing_tb;
  import epp_pkg::*;
  localparam int TK = 20;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  epp_objreq_s req = '0;
  epp_objrsp_s rsp;
  epp_msg_s    msg;
  logic [31:0] raw = 32'h0;
  logic [1:0]  tx = 2'h0;
  logic [1:0]  ev = 2'h0;
  logic        rv = 1'b0, er = 1'b0, stall = 1'b0, ramp = 1'b0;
  logic        mv, mr, pc, sc, rc, e;
  logic [31:0] pos, rd, inc, acc, offs, steps, xp, w[4];
  logic [15:0] opr;
  logic [7:0]  xf;
  logic [31:0] rs = 32'h3dad;
  int          n_mismatch = 0, n_checks = 0, cyc = 0, npc = 0, n0, k;
  int          ln[3] = '{4, 5, 8};
  logic [15:0] bix[4] = '{16'h2004, 16'h2000, 16'h6001, 16'h3000};

  epp_position #(.TICKS(TK)) dut (.CLK(CLK), .RST_N(RST_N),
    .OBJ_REQ(req), .OBJ_RSP(rsp), .RAW_POS(raw), .RAW_VALID(rv),
    .TX_REQ(tx), .EVENT_MODE(ev), .ENC_RESET(er), .MSG_OUT(msg),
    .MSG_VALID(mv), .MSG_READY(mr), .PRESET_CLEAR(pc),
    .SELF_CHECK_EN(sc), .RESID_COMP(rc), .POSITION(pos));
  epp_master_model m (.CLK(CLK), .RST_N(RST_N), .MSG_OUT(msg),
    .MSG_VALID(mv), .STALL(stall), .MSG_READY(mr));

  initial forever #5 CLK = ~CLK;
  // hang guard, well above the expected run length
  always @(posedge CLK) begin
    cyc++;
    if (pc === 1'b1) npc++;
    if (cyc == 50000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // quadratic ramp source for speed and acceleration
  always @(posedge CLK) if (ramp) begin
    #1 raw = raw + inc;
    rv = 1'b1;
    inc = inc + acc;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] xpos(logic [31:0] r);
    logic [63:0] p;
    p = {32'h0, opr[0] ? 32'h0 - r : r};
    if (opr[2]) p = (p * steps) / 64'h2000;
    return p[31:0] + offs;
  endfunction
  function automatic logic [7:0] xflg(logic [31:0] p);
    logic [7:0] f;
    f = 8'h0;
    for (int i = 0; i < 4; i++) begin
      f[2*i] = w[i][31] && p > {2'b0, w[i][29:0]};
      f[2*i+1] = w[i][30] && p < {2'b0, w[i][29:0]};
    end
    return f;
  endfunction

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic obj(logic wn, logic [15:0] ix, logic [7:0] sb,
                     logic [31:0] wd);
    @(posedge CLK);
    #1 req = '{ix, sb, wn, !wn, wd};
    @(posedge CLK);
    #1 req.wr = 1'b0;
    req.rd = 1'b0;
    k = 0;
    while (rsp.ack !== 1'b1 && k < 4) begin
      @(posedge CLK);
      #1 k++;
    end
    rd = rsp.rdata;
    e = rsp.err;
    if (k == 4) chk("ack", 32'h0, 32'h1);
  endtask
  task automatic rdc(string nm, logic [15:0] ix, logic [7:0] sb,
                     logic [31:0] exp);
    obj(1'b0, ix, sb, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic wr(logic [15:0] ix, logic [7:0] sb, logic [31:0] wd);
    obj(1'b1, ix, sb, wd);
    chk("werr", {31'h0, e}, 32'h0);
  endtask
  task automatic cfg();
    wr(16'h6000, 8'h0, {16'h0, opr});
    wr(16'h6001, 8'h0, steps);
    wr(16'h2001, 8'h0, offs);
    for (int i = 0; i < 4; i++) wr(16'h2000, 8'(i + 1), w[i]);
  endtask
  task automatic samp(logic [31:0] r);
    @(posedge CLK);
    #1 raw = r;
    rv = 1'b1;
    @(posedge CLK);
    #1 rv = 1'b0;
    repeat (2) @(posedge CLK);
    #1 xp = xpos(r);
    xf = xflg(xp);
  endtask
  task automatic pulse(logic [1:0] v);
    @(posedge CLK);
    #1 tx = v;
    @(posedge CLK);
    #1 tx = 2'h0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge CLK);
    #1 RST_N = 1'b1;
    rdc("cnt", 16'h2000, 8'h0, 32'h4);
    rdc("thr", 16'h2000, 8'h3, 32'h0);
    rdc("offs", 16'h2001, 8'h0, 32'h0);
    rdc("lay", 16'h2005, 8'h0, 32'h0);
    rdc("oper", 16'h6000, 8'h0, 32'h0);
    rdc("steps", 16'h6001, 8'h0, 32'h2000);
    rdc("id1", 16'h1800, 8'h1, 32'h0);
    rdc("id2", 16'h1802, 8'h1, 32'h8000_0000);
    for (int i = 0; i < 4; i++) begin
      obj(1'b1, bix[i], 8'h0, 32'h2001);
      chk("rej", {31'h0, e}, 32'h1);
    end
    rdc("steps", 16'h6001, 8'h0, 32'h2000);
    $display("test 1 done");
    n0 = npc;
    wr(16'h6000, 8'h0, 32'hffff);
    rdc("oper", 16'h6000, 8'h0, 32'h1007);
    chk("selfchk", {31'h0, sc}, 32'h1);
    chk("resid0", {31'h0, rc}, 32'h0);
    chk("pclr", 32'(npc - n0), 32'h1);
    @(posedge CLK);
    #1 er = 1'b1;
    @(posedge CLK);
    #1 er = 1'b0;
    repeat (2) @(posedge CLK);
    chk("resid1", {31'h0, rc}, 32'h1);
    wr(16'h6000, 8'h0, 32'h0);
    // let the direction-change pulse be counted before the baseline
    @(posedge CLK);
    #1 n0 = npc;
    wr(16'h6000, 8'h0, 32'h4);
    wr(16'h6001, 8'h0, 32'h1000);
    repeat (2) @(posedge CLK);
    chk("pclr", 32'(npc - n0), 32'h2);
    $display("test 2 done");
    for (int n = 0; n < 16; n++) begin
      opr = 16'(xs() & 32'h0000_0005);
      if (opr[0]) opr[2] = 1'b0;
      steps = xs() % 32'h2001;
      offs = {{8{rs[23]}}, rs[23:0]};
      raw = xs() & 32'h3ffff;
      for (int i = 0; i < 4; i++)
        w[i] = (xs() & 32'hc000_0000) |
               ((xpos(raw) + i - 2) & 32'h3fff_ffff);
      cfg();
      samp(raw);
      chk("pos", pos, xp);
      rdc("flg", 16'h2004, 8'h0, {24'h0, xf});
    end
    $display("test 3 done");
    repeat (3 * TK) @(posedge CLK);
    wr(16'h1802, 8'h1, 32'h0);
    for (int l = 0; l < 3; l++) begin
      wr(16'h2005, 8'h0, {24'h0, l[3:0], l[3:0]});
      m.q.delete();
      pulse(2'h3);
      // master ready is random, so wait for both or a bound
      k = 0;
      while (m.q.size() < 2 && k < 60) begin
        @(posedge CLK);
        k++;
      end
      repeat (4) @(posedge CLK);
      chk("nmsg", m.q.size(), 32'h2);
      for (int j = 0; j < 2; j++) begin
        chk("sel", {31'h0, m.q[j].sel}, j);
        chk("len", {28'h0, m.q[j].len}, ln[l]);
        chk("lo", m.q[j].data[31:0], xp);
        chk("hi", m.q[j].data[63:32],
            l == 1 ? {24'h0, xf} : 32'h0);
      end
    end
    wr(16'h1802, 8'h1, 32'h8000_0000);
    m.q.delete();
    pulse(2'h2);
    repeat (12) @(posedge CLK);
    chk("dis", m.q.size(), 32'h0);
    $display("test 4 done");
    opr = 16'h0;
    offs = 32'h0;
    w = '{32'h8000_1000, 32'h0, 32'h0, 32'h0};
    cfg();
    wr(16'h2005, 8'h0, 32'h01);
    ev = 2'h1;
    samp(32'h0800);
    repeat (8) @(posedge CLK);
    m.q.delete();
    samp(32'h1800);
    repeat (8) @(posedge CLK);
    chk("evt", m.q.size(), 32'h1);
    chk("evf", {24'h0, m.q[0].data[39:32]}, 32'h1);
    samp(32'h1800);
    repeat (8) @(posedge CLK);
    chk("evn", m.q.size(), 32'h1);
    #1 ev = 2'h0;
    $display("test 5 done");
    wr(16'h2005, 8'h0, 32'h0);
    m.q.delete();
    stall = 1'b1;
    // one request beyond depth must wait pending, not be lost
    repeat (33) pulse(2'h1);
    repeat (4) @(posedge CLK);
    chk("full", {31'h0, mv}, 32'h1);
    #1 stall = 1'b0;
    k = 0;
    while (m.q.size() < 33 && k < 400) begin
      @(posedge CLK);
      k++;
    end
    repeat (4) @(posedge CLK);
    chk("drain", m.q.size(), 32'd33);
    chk("empty", {31'h0, mv}, 32'h0);
    $display("test 6 done");
    #1 inc = 32'h1;
    acc = 32'h0;
    ramp = 1'b1;
    repeat (3 * TK) @(posedge CLK);
    rdc("spd", 16'h2002, 8'h0, TK);
    @(posedge CLK);
    #3 inc = 32'hffff_ffff;
    repeat (3 * TK) @(posedge CLK);
    rdc("spdn", 16'h2002, 8'h0, 32'h0000_ffec);
    @(posedge CLK);
    #3 inc = 32'h0;
    acc = 32'h1;
    repeat (4 * TK) @(posedge CLK);
    rdc("acc", 16'h2003, 8'h0, TK * TK);
    @(posedge CLK);
    #3 ramp = 1'b0;
    rv = 1'b0;
    $display("test 7 done");
    wr(16'h2005, 8'h0, 32'h22);
    @(posedge CLK);
    #1 RST_N = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'b1;
    rdc("lay", 16'h2005, 8'h0, 32'h0);
    rdc("id2", 16'h1802, 8'h1, 32'h8000_0000);
    wr(16'h2005, 8'h0, 32'h22);
    rdc("lay", 16'h2005, 8'h0, 32'h22);
    $display("test 8 done");
    tally_and_finish();
  end
endmodule
